/* lcd_drive_pkg.sv */
// Constants, field layouts and carrier types for the LCD drive timing block
package lcd_drive_pkg;

  // Clock and oscillator rate
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned OSC_HZ   = 270_000;
  localparam int unsigned HALF_DIV = CLK_HZ / (2 * OSC_HZ);
  localparam logic [7:0]  HALF_MAX = 8'(HALF_DIV - 1);

  // Register map, word addresses on the plain register port
  localparam logic [1:0]  ADDR_CTRL   = 2'h0;
  localparam logic [1:0]  ADDR_WAVE   = 2'h1;
  localparam logic [1:0]  ADDR_STATUS = 2'h2;

  // Control register fields
  localparam int unsigned CTRL_TWO_LINE = 0;
  localparam int unsigned CTRL_FONT_TALL = 1;
  localparam int unsigned CTRL_CHARS_LSB = 2;
  localparam logic [15:0] CTRL_RST = 16'h0040;
  // Waveform register fields
  localparam int unsigned WAVE_STD = 0;
  localparam int unsigned WAVE_EXT = 1;
  localparam logic [15:0] WAVE_RST = 16'h0000;
  // Status register fields
  localparam int unsigned STAT_ROW_LSB = 0;
  localparam int unsigned STAT_POL     = 4;
  localparam int unsigned STAT_EXT     = 5;
  localparam int unsigned STAT_WAVE    = 6;
  localparam int unsigned STAT_TWO     = 7;

  // Geometry
  localparam int unsigned SEG_N      = 80;
  localparam int unsigned COM_N      = 16;
  localparam logic [2:0]  CHAR_W     = 3'h5;
  localparam logic [6:0]  CHARS_INT  = 7'h10;
  localparam logic [6:0]  CHARS_1L   = 7'h50;
  localparam logic [6:0]  CHARS_2L   = 7'h28;
  localparam logic [8:0]  MAX_POS_1L = 9'h190;
  localparam logic [8:0]  MAX_POS_2L = 9'h0C8;
  localparam logic [4:0]  DUTY_8     = 5'h08;
  localparam logic [4:0]  DUTY_11    = 5'h0B;
  localparam logic [4:0]  DUTY_16    = 5'h10;
  localparam logic [3:0]  LINE2_ROW  = 4'h8;

  typedef enum logic [1:0] {
    ST_SHIFT = 2'b00,
    ST_IDLE  = 2'b01,
    ST_LATCH = 2'b11
  } row_state_t;

  // Member order follows the control word: chars on [8:2], font on [1], lines on [0]
  typedef struct packed {
    logic [6:0] chars;
    logic       font_tall;
    logic       two_line;
  } drive_cfg_t;

  typedef struct packed {
    logic seg_data;
    logic seg_shift_strobe;
    logic seg_latch_strobe;
    logic polarity;
  } ext_link_t;

endpackage

/* lcd_drive.sv */
// Row scan, serial segment feed and polarity generator of the character LCD drive
//
// Function
// - Own 80 segment outputs always show the first 16 characters of a line.
// - Extension drivers chain onto the serial data output, lengthening the shift chain.
// - Shift length per row at most 400 one-line, 200 two-line.
// - Extension link is data, shift strobe, latch strobe and polarity.
// - Duty is 1/8 or 1/11 one-line by font, 1/16 two-line.
// - Exactly duty-many common lines are scanned; the rest stay passive.
// - Line inversion: polarity changes twice per row, at both latch edges.
// - Frame inversion: polarity toggles once per full frame.
// - Waveform type set separately for standard and extended mode.
// - Reset alone brings the block to a working default state.
// - Data shifts at oscillator rate, last character of the line first.
// - Latch strobe fall latches segments and advances the common line.
// - Readable flag gives the waveform type: 0 line, 1 frame inversion.
module lcd_drive
  import lcd_drive_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ext_mode_n_i,
  input  wire logic [1:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [15:0]       reg_rdata_o,
  output logic      [6:0]        char_addr_o,
  output logic      [3:0]        font_row_o,
  input  wire logic [4:0]        glyph_bits_i,
  output ext_link_t              link_o,
  output logic      [COM_N-1:0]  common_row_outputs_o,
  output logic      [SEG_N-1:0]  segment_column_outputs_o
);

  function automatic logic [3:0] row_inc(input logic [3:0] row, input logic [4:0] duty);
    logic [4:0] nxt;
    nxt = {1'b0, row} + 5'h01;
    return (nxt >= duty) ? 4'h0 : nxt[3:0];
  endfunction

  drive_cfg_t       cfg_reg;
  logic [1:0]       wave_reg;
  logic             ext_meta_reg;
  logic             ext_sync_reg;
  logic [7:0]       half_cnt_reg;
  logic             phase_reg;
  row_state_t       state_reg;
  row_state_t       state_next;
  logic [8:0]       slot_reg;
  logic [8:0]       slot_next;
  logic [6:0]       char_idx_reg;
  logic [2:0]       bit_idx_reg;
  logic [4:0]       glyph_reg;
  logic [SEG_N-1:0] shreg_reg;
  logic [3:0]       row_reg;
  logic [3:0]       fill_row_reg;
  logic             seg_data_reg;
  logic             shift_stb_reg;
  logic             latch_stb_reg;
  logic             pol_reg;
  logic [COM_N-1:0] com_reg;
  logic [SEG_N-1:0] seg_latch_reg;
  logic [15:0]      rdata_reg;

  logic             half_tick;
  logic             slot_start;
  logic             slot_mid;
  logic             ext_active;
  logic             wave_frame;
  logic [4:0]       duty;
  logic [6:0]       chars_max;
  logic [6:0]       nchars;
  logic [8:0]       npos;
  logic [8:0]       pos_limit;
  logic             new_bit;
  logic [3:0]       scan_row;

  // Mode pin comes from outside, so it is synchronised before use
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ~ext_mode_n_i;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  assign ext_active = ext_sync_reg;
  assign wave_frame = ext_active ? wave_reg[WAVE_EXT] : wave_reg[WAVE_STD];

  // Mode decode
  always_comb
  begin
    duty = cfg_reg.two_line ? DUTY_16 : (cfg_reg.font_tall ? DUTY_11 : DUTY_8);
    chars_max = cfg_reg.two_line ? CHARS_2L : CHARS_1L;
    pos_limit = cfg_reg.two_line ? MAX_POS_2L : MAX_POS_1L;
    // Never fewer than the internal characters, never more than the row cycle allows
    if (cfg_reg.chars < CHARS_INT)
      nchars = CHARS_INT;
    else if (cfg_reg.chars > chars_max)
      nchars = chars_max;
    else
      nchars = cfg_reg.chars;
    npos = 9'(nchars * CHAR_W);
  end

  // Register port; settings reset to one line, 5x8, 16 characters
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_reg  <= drive_cfg_t'(CTRL_RST[8:0]);
      wave_reg <= WAVE_RST[1:0];
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == ADDR_CTRL)
        cfg_reg <= drive_cfg_t'(reg_wdata_i[8:0]);
      else if (reg_addr_i == ADDR_WAVE)
        wave_reg <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_CTRL:   rdata_reg <= {7'h00, cfg_reg};
        ADDR_WAVE:   rdata_reg <= {14'h0000, wave_reg};
        ADDR_STATUS: rdata_reg <= {8'h00, cfg_reg.two_line, wave_frame, ext_active,
                                   pol_reg, row_reg};
        default:     rdata_reg <= 16'h0000;
      endcase
    end
    else
      rdata_reg <= 16'h0000;
  end

  assign reg_rdata_o = rdata_reg;

  // Oscillator rate: two half-ticks per shift slot
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      half_cnt_reg <= 8'h00;
      phase_reg    <= 1'b1;
    end
    else if (half_tick)
    begin
      half_cnt_reg <= 8'h00;
      phase_reg    <= ~phase_reg;
    end
    else
      half_cnt_reg <= half_cnt_reg + 8'h01;
  end

  assign half_tick  = (half_cnt_reg == HALF_MAX);
  assign slot_start = half_tick & phase_reg;
  assign slot_mid   = half_tick & ~phase_reg;

  // Row sequence: shift slots, idle fill to the fixed row cycle, then one latch slot
  always_comb
  begin
    slot_next = (state_reg == ST_LATCH) ? 9'h000 : slot_reg + 9'h001;
    if (slot_next < npos)
      state_next = ST_SHIFT;
    else if (slot_next >= pos_limit)
      state_next = ST_LATCH;
    else
      state_next = ST_IDLE;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_LATCH;
      slot_reg  <= 9'h000;
    end
    else if (slot_start)
    begin
      case (state_next)
        ST_SHIFT: state_reg <= ST_SHIFT;
        ST_IDLE:  state_reg <= ST_IDLE;
        ST_LATCH: state_reg <= ST_LATCH;
        default:  state_reg <= ST_IDLE;
      endcase
      slot_reg <= slot_next;
    end
  end

  // Strobes high for the first half of their slot
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_stb_reg <= 1'b0;
      latch_stb_reg <= 1'b0;
    end
    else if (slot_start)
    begin
      shift_stb_reg <= (state_next == ST_SHIFT);
      latch_stb_reg <= (state_next == ST_LATCH);
    end
    else if (slot_mid)
    begin
      shift_stb_reg <= 1'b0;
      latch_stb_reg <= 1'b0;
    end
  end

  assign new_bit = (bit_idx_reg == 3'h0) ? glyph_bits_i[0] : glyph_reg[0];

  // Serial feed; data changes at slot start so it is stable around the strobe fall
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      char_idx_reg <= CHARS_INT - 7'h01;
      bit_idx_reg  <= 3'h0;
      glyph_reg    <= 5'h00;
      shreg_reg    <= '0;
      seg_data_reg <= 1'b0;
    end
    else if (slot_start && state_next == ST_SHIFT)
    begin
      // The bit falling out of the internal chain continues into the extension chain
      seg_data_reg <= shreg_reg[SEG_N-1];
      shreg_reg    <= {shreg_reg[SEG_N-2:0], new_bit};
      if (bit_idx_reg == 3'h0)
        glyph_reg <= {1'b0, glyph_bits_i[4:1]};
      else
        glyph_reg <= {1'b0, glyph_reg[4:1]};
      if (bit_idx_reg == CHAR_W - 3'h1)
      begin
        bit_idx_reg  <= 3'h0;
        char_idx_reg <= char_idx_reg - 7'h01;
      end
      else
        bit_idx_reg <= bit_idx_reg + 3'h1;
    end
    // Outside shift slots the start character follows the line length, also after reset
    else if (state_reg != ST_SHIFT)
    begin
      char_idx_reg <= nchars - 7'h01;
      bit_idx_reg  <= 3'h0;
    end
  end

  // A shorter duty can leave the fill row out of range, so the scan restarts at row 0
  assign scan_row = ({1'b0, fill_row_reg} < duty) ? fill_row_reg : 4'h0;

  // Latch fall: segments take the chain, scan moves to the row just filled
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seg_latch_reg <= '0;
      row_reg       <= 4'h0;
      fill_row_reg  <= 4'h1;
      com_reg       <= 16'h0001;
    end
    else if (slot_mid && state_reg == ST_LATCH)
    begin
      seg_latch_reg <= shreg_reg;
      row_reg       <= scan_row;
      fill_row_reg  <= row_inc(scan_row, duty);
      com_reg       <= 16'h0001 << scan_row;
    end
  end

  // Line inversion flips at both latch edges, frame inversion only at frame wrap
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pol_reg <= 1'b0;
    else if (slot_start && state_next == ST_LATCH && !wave_frame)
      pol_reg <= ~pol_reg;
    else if (slot_mid && state_reg == ST_LATCH)
    begin
      if (!wave_frame || scan_row == 4'h0)
        pol_reg <= ~pol_reg;
    end
  end

  assign char_addr_o = (cfg_reg.two_line && fill_row_reg >= LINE2_ROW)
                       ? 7'(char_idx_reg + CHARS_2L) : char_idx_reg;
  assign font_row_o  = cfg_reg.two_line ? {1'b0, fill_row_reg[2:0]} : fill_row_reg;

  assign link_o.seg_data         = seg_data_reg;
  assign link_o.seg_shift_strobe = shift_stb_reg;
  assign link_o.seg_latch_strobe = latch_stb_reg;
  assign link_o.polarity         = pol_reg;
  assign common_row_outputs_o     = com_reg;
  assign segment_column_outputs_o = seg_latch_reg;

  // Checks
  com_onehot_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $onehot(com_reg) && com_reg == (16'h0001 << row_reg))
    else $error("common outputs not one-hot on the scanned row");

  row_duty_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(latch_stb_reg) |-> ({1'b0, row_reg} < duty))
    else $error("scanned row beyond duty");

  shift_limit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    npos <= pos_limit && npos >= 9'(SEG_N))
    else $error("shift length outside the allowed range");

  strobe_excl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(shift_stb_reg && latch_stb_reg))
    else $error("shift and latch strobes overlap");

  pol_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $changed(pol_reg) |-> ($rose(latch_stb_reg) || $fell(latch_stb_reg)))
    else $error("polarity changed away from a latch edge");

  line_inv_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($fell(latch_stb_reg) && !wave_frame && !$past(wave_frame, HALF_DIV + 2)) |->
    ($changed(pol_reg) && pol_reg == $past(pol_reg, HALF_DIV + 2)))
    else $error("line inversion did not flip twice per row");

  frame_inv_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($changed(pol_reg) && wave_frame) |-> (row_reg == 4'h0 && $fell(latch_stb_reg)))
    else $error("frame inversion flipped inside a frame");

  seg_latch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(latch_stb_reg) |-> (seg_latch_reg == $past(shreg_reg) &&
    row_reg == $past(scan_row)))
    else $error("latch fall did not load segments and advance the row");

  reverse_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($rose(shift_stb_reg) && slot_reg == 9'h000) |-> $past(char_idx_reg) == nchars - 7'h01)
    else $error("row did not start with the last character");

  wave_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(reg_rd_i) && $past(reg_addr_i) == ADDR_STATUS |->
    reg_rdata_o[STAT_WAVE] == $past(wave_frame))
    else $error("status waveform flag wrong");

  frame_wrap_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wave_frame && $changed(pol_reg));
  two_line_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg_reg.two_line && $fell(latch_stb_reg) && row_reg == 4'hF);
  long_chain_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(shift_stb_reg) && slot_reg == 9'h18F);
  ext_mode_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    ext_active && $fell(latch_stb_reg));

endmodule

/* lcd_ext_chain_model.sv */
// Behavioural model of cascaded segment extension drivers on the serial link
module lcd_ext_chain_model
  import lcd_drive_pkg::*;
#(
  parameter int unsigned LEN = 20
)
(
  input  wire ext_link_t       link_i,
  output logic     [LEN-1:0] seg_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [LEN-1:0] chain_reg;

  // The chain extends the device register; data is held past the strobe fall
  always @(negedge link_i.seg_shift_strobe)
  begin
    chain_reg <= {chain_reg[LEN-2:0], link_i.seg_data};
  end

  // Latch strobe fall moves the chain onto the driver outputs
  always @(negedge link_i.seg_latch_strobe)
  begin
    seg_o <= chain_reg;
  end
endmodule

/* char_lcd_drive_and_extension_tb.sv */
// Self-checking bench of the LCD drive timing block with an extension chain model
module char_lcd_drive_and_extension_tb;
  import lcd_drive_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        wr;
    logic [1:0]  a;
    logic [15:0] d;
    logic [15:0] exp;
  } reg_row_t;

  // Reset values, refused writes, waveform flags, then two-line mode with 20 characters
  localparam reg_row_t ROWS [14] = '{
    {1'b0, 2'h0, 16'h0000, 16'h0040}, {1'b0, 2'h1, 16'h0000, 16'h0000},
    {1'b0, 2'h2, 16'h0000, 16'h0000}, {1'b0, 2'h3, 16'h0000, 16'h0000},
    {1'b1, 2'h3, 16'hFFFF, 16'h0000}, {1'b1, 2'h2, 16'hFFFF, 16'h0000},
    {1'b0, 2'h2, 16'h0000, 16'h0000}, {1'b1, 2'h1, 16'h0003, 16'h0000},
    {1'b0, 2'h1, 16'h0000, 16'h0003}, {1'b0, 2'h2, 16'h0000, 16'h0040},
    {1'b1, 2'h1, 16'h0000, 16'h0000}, {1'b1, 2'h0, 16'h0051, 16'h0000},
    {1'b0, 2'h0, 16'h0000, 16'h0051}, {1'b0, 2'h2, 16'h0000, 16'h0080}
  };

  logic              ref_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              ext_mode_n_i = 1'b1;
  logic [1:0]        reg_addr_i = 2'h0;
  logic [15:0]       reg_wdata_i = 16'h0000;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [15:0]       reg_rdata_o;
  logic [6:0]        char_addr_o;
  logic [3:0]        font_row_o;
  logic [4:0]        glyph_bits_i;
  ext_link_t         link_o;
  logic [COM_N-1:0]  common_row_outputs_o;
  logic [SEG_N-1:0]  segment_column_outputs_o;
  logic [19:0]       ext_seg;
  ext_link_t         prev_q;
  int unsigned       sh_hi, la_hi, shifts, row_shifts, pol_cnt, since_q, period_q;
  int unsigned       n_errors = 0;
  int unsigned       compares = 0;
  int unsigned       cycles = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  // Glyph source answers combinationally, as the fill logic samples it in the same cycle
  assign glyph_bits_i = char_addr_o[4:0] ^ {1'b0, font_row_o};

  lcd_drive lcd_drive_inst (
    .ref_clk_i                (ref_clk_i),
    .rst_i                    (rst_i),
    .ext_mode_n_i             (ext_mode_n_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_wr_i                 (reg_wr_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_rdata_o              (reg_rdata_o),
    .char_addr_o              (char_addr_o),
    .font_row_o               (font_row_o),
    .glyph_bits_i             (glyph_bits_i),
    .link_o                   (link_o),
    .common_row_outputs_o     (common_row_outputs_o),
    .segment_column_outputs_o (segment_column_outputs_o)
  );

  lcd_ext_chain_model #(.LEN(20)) lcd_ext_chain_model_inst (
    .link_i (link_o),
    .seg_o  (ext_seg)
  );

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic reg_op(input logic wr, input logic [1:0] a, input logic [15:0] d, exp);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d; // Whole word in one transfer keeps the host order
    reg_wr_i    <= wr;
    reg_rd_i    <= !wr;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    if (!wr)
      check(32'(reg_rdata_o), 32'(exp), "register read");
  endtask

  task automatic wait_latch_fall();
    logic        was;
    int unsigned n;
    was = 1'b0;
    n = 0;
    while (n < 40000)
    begin
      @(negedge ref_clk_i);
      n++;
      if (was && !link_o.seg_latch_strobe)
        break;
      was = link_o.seg_latch_strobe;
    end
    // The monitor sees the fall one edge later, so let its counters settle first
    @(negedge ref_clk_i);
    if (n >= 40000)
      check(32'h0, 32'h1, "latch strobe missing");
  endtask

  // Stream bit k of the last 20 leaving the device: character 19 - k/5, glyph bit k%5, oldest first
  function automatic logic [19:0] ext_expect(input logic [3:0] frow);
    logic [19:0] v;
    logic [4:0]  g;
    for (int k = 0; k < 20; k++)
    begin
      g = 5'(19 - k / 5) ^ {1'b0, frow};
      v[19-k] = g[k%5];
    end
    return v;
  endfunction

  // Segment order on the own outputs is not pinned down, so only the lit count is compared
  function automatic logic [31:0] int_ones(input logic [3:0] frow);
    logic [31:0] s;
    s = 0;
    for (int c = 0; c < 16; c++)
      s = s + 32'($countones(5'(c) ^ {1'b0, frow}));
    return s;
  endfunction

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      prev_q <= '0;
      sh_hi <= 0;
      la_hi <= 0;
      shifts <= 0;
      pol_cnt <= 0;
      since_q <= 0;
    end
    else
    begin
      prev_q <= link_o;
      sh_hi <= link_o.seg_shift_strobe ? sh_hi + 1 : 0;
      la_hi <= link_o.seg_latch_strobe ? la_hi + 1 : 0;
      since_q <= since_q + 1;
      if (prev_q.seg_shift_strobe && !link_o.seg_shift_strobe)
      begin
        shifts <= shifts + 1;
        check(sh_hi, 32'(HALF_DIV), "shift strobe width");
      end
      if (!prev_q.seg_latch_strobe && link_o.seg_latch_strobe)
      begin
        row_shifts <= shifts;
        shifts <= 0;
      end
      if (prev_q.seg_latch_strobe && !link_o.seg_latch_strobe)
      begin
        period_q <= since_q;
        since_q <= 0;
        check(la_hi, 32'(HALF_DIV), "latch strobe width");
      end
      if (prev_q.polarity !== link_o.polarity)
      begin
        pol_cnt <= pol_cnt + 1;
        check(32'(prev_q.seg_latch_strobe ^ link_o.seg_latch_strobe), 32'h1, "polarity edge");
      end
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    check(32'(common_row_outputs_o), 32'h0001, "reset common");
    check(32'({link_o, reg_rdata_o}), 32'h0, "reset link");
    rst_i <= 1'b0;
    foreach (ROWS[i])
      reg_op(ROWS[i].wr, ROWS[i].a, ROWS[i].d, ROWS[i].exp);
    wait_latch_fall();
    check(row_shifts, 32'd100, "shifts per row");
    check(pol_cnt, 32'd2, "line inversion changes");
    check(32'(common_row_outputs_o), 32'h0002, "common after latch");
    check(32'(ext_seg), 32'(ext_expect(4'h1)), "extension chain row 1");
    check(32'($countones(segment_column_outputs_o)), int_ones(4'h1), "own segments");
    @(posedge ref_clk_i);
    ext_mode_n_i <= 1'b0;
    reg_op(1'b1, 2'h1, 16'h0002, 16'h0000);
    repeat (3) @(posedge ref_clk_i);
    reg_op(1'b0, 2'h2, 16'h0000, 16'h00E1);
    wait_latch_fall();
    check(pol_cnt, 32'd2, "frame inversion mid frame");
    check(32'(common_row_outputs_o), 32'h0004, "common row 2");
    check(period_q, 32'(201 * 148 - 1), "row cycle length");
    check(32'(ext_seg), 32'(ext_expect(4'h2)), "extension chain row 2");
    @(posedge ref_clk_i);
    ext_mode_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reg_op(1'b0, 2'h2, 16'h0000, 16'h0082);
    tally_and_finish();
  end
endmodule
